// File: hw/bus_recovery.sv
/*
  clock pulses to free a data line held low by a slave.
  assumes sda_sync and scl_sync are already synchronised to pclk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "i2c_front_params.svh"

module bus_recovery #(
  parameter int HALF_CYC = `RECOV_HALF_CYC,
  parameter int MAX_PULSES = `RECOV_MAX_PULSES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic sda_sync,
  input wire logic scl_sync,
  output logic scl_oe,
  output logic busy,
  output logic released
);

  i2c_front_pkg::recov_state_t state_reg;
  logic [15:0] timer_reg;
  logic [3:0] pulses_reg;
  logic half_done;

  assign half_done = (timer_reg == 16'(HALF_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= i2c_front_pkg::REC_IDLE;
      timer_reg <= 16'h0000;
      pulses_reg <= 4'h0;
      scl_oe <= 1'b0;
      released <= 1'b0;
    end else begin
      unique case (state_reg)
        i2c_front_pkg::REC_IDLE: begin
          if (start) begin
            state_reg <= i2c_front_pkg::REC_LOW;
            timer_reg <= 16'h0000;
            pulses_reg <= 4'h0;
            scl_oe <= 1'b1;
            released <= 1'b0;
          end
        end
        i2c_front_pkg::REC_LOW: begin
          timer_reg <= half_done ? 16'h0000 : timer_reg + 16'h0001;
          if (half_done) begin
            state_reg <= i2c_front_pkg::REC_HIGH;
            pulses_reg <= pulses_reg + 4'h1;
            scl_oe <= 1'b0;
          end
        end
        i2c_front_pkg::REC_HIGH: begin
          if (!half_done) begin
            timer_reg <= timer_reg + 16'h0001;
          end else if (scl_sync) begin
            timer_reg <= 16'h0000;
            if (sda_sync) begin
              state_reg <= i2c_front_pkg::REC_IDLE;
              released <= 1'b1;
            end else if (pulses_reg == 4'(MAX_PULSES)) begin
              state_reg <= i2c_front_pkg::REC_IDLE;
            end else begin
              state_reg <= i2c_front_pkg::REC_LOW;
              scl_oe <= 1'b1;
            end
          end
        end
        default: begin
          state_reg <= i2c_front_pkg::REC_IDLE;
          scl_oe <= 1'b0;
        end
      endcase
    end
  end

  assign busy = (state_reg != i2c_front_pkg::REC_IDLE);

  property p_pulse_limit;
    @(posedge pclk) disable iff (!presetn)
    pulses_reg <= 4'(MAX_PULSES);
  endproperty
  a_pulse_limit: assert property (p_pulse_limit) else $error("too many recovery pulses");

  sequence s_sample_high;
    state_reg == i2c_front_pkg::REC_HIGH && half_done && scl_sync && sda_sync;
  endsequence
  property p_stop_on_release;
    @(posedge pclk) disable iff (!presetn)
    s_sample_high |=> !busy && released && !scl_oe;
  endproperty
  a_stop_on_release: assert property (p_stop_on_release) else $error("recovery ran on");

endmodule : bus_recovery
`default_nettype wire

// File: hw/i2c_event_register_front.sv
/*
  register file, interrupt, dma events, debug suspend and bus recovery of a
  two-wire serial controller, reached over apb.
  assumes the serial core runs on pclk and reports its events as core_evt pulses
  and levels; pins sda_in, scl_in and debug_suspend are asynchronous.
*/
// Overview of operation
// - one dedicated interrupt output, shared with nothing else.
// - receive byte copied into receive data register pulses the rx dma event.
// - transmit byte taken into the shift register pulses the tx dma event.
// - debug suspend stops the core unless the free-run bit is set.
// - bus recovery drives up to nine clock pulses on the clock line.
// - after each pulse the data line is sampled while the clock is high.
// - recovery stops once the data line reads high; a start may follow.
// - register offsets 0h to 38h decoded as in the register map.
// - 7-bit addressing matches own address bits 6-0 only.
// - 10-bit addressing matches own address bits 9-0.
// - reserved bits read zero and ignore writes.
// - enable register holds one bit per event, bits 0 to 6.
// - status flags clear on writing one; read-only bits ignore writes.
// - after reset only tx-shift-empty and tx-ready status bits are one.
// - events set flags whenever the module runs; enable bits gate them to the interrupt.
// - vector read clears the top pending flag except addressed-as-slave, which follows the core level; the rest re-raise interrupt.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_front_params.svh"

module i2c_event_register_front #(
  parameter logic [31:0] PERIPH_ID1 = 32'h0000_0101,
  parameter logic [31:0] PERIPH_ID2 = 32'h0000_0002,
  parameter int RECOV_HALF = `RECOV_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire i2c_front_pkg::core_evt_t core_evt,
  input wire logic [7:0] rx_byte,
  input wire logic [9:0] rx_slave_addr,
  input wire logic debug_suspend,
  input wire logic sda_in,
  input wire logic scl_in,
  output logic irq,
  output logic rx_dma_request,
  output logic tx_dma_request,
  output logic core_run,
  output logic addr_match,
  output logic [7:0] tx_byte,
  output logic scl_oe
);

  // id values are arbitrary
  logic [9:0] own_addr_reg;
  logic [6:0] int_en_reg;
  logic [14:0] status_reg;
  logic [15:0] clk_low_reg;
  logic [15:0] clk_high_reg;
  logic [15:0] count_reg;
  logic [7:0] rx_data_reg;
  logic [9:0] slave_addr_reg;
  logic [15:0] mode_reg;
  logic [7:0] ext_mode_reg;
  logic [7:0] prescale_reg;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [31:0] rdata_next;
  logic [6:0] sources;
  logic [2:0] vec_code;
  logic wr_acc;
  logic rd_acc;
  logic recov_start;
  logic recov_busy;
  logic recov_ok;
  logic match_raw;
  logic module_run_enable;
  logic [14:0] status_clr;
  logic [14:0] status_set;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `OFF_PERIPH_ID2);
  endfunction : mapped

  // lowest source index wins; code 0 means none pending
  function automatic logic [2:0] top_code(input logic [6:0] pend);
    top_code = 3'h0;
    for (int i = 6; i >= 0; i--) begin
      if (pend[i]) begin
        top_code = 3'(i + 1);
      end
    end
  endfunction : top_code

  assign module_run_enable = mode_reg[`MODE_IRS];
  assign sources = {status_reg[`ST_AAS], status_reg[5:0]};
  assign vec_code = top_code(sources & int_en_reg);
  assign wr_acc = psel && penable && pready && pwrite;
  assign rd_acc = psel && penable && pready && !pwrite;
  assign recov_start = wr_acc && (paddr == `OFF_EXT_MODE) && pwdata[`EXT_RECOV_START];

  // pins: two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
    end else begin
      sync1_reg <= {debug_suspend, sda_in, scl_in};
      sync2_reg <= sync1_reg;
    end
  end

  // no wait state: answer prepared in setup, pready high in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
      prdata <= (psel && !penable && !pwrite) ? rdata_next : 32'h0000_0000;
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (paddr)
      `OFF_OWN_ADDR: rdata_next[9:0] = own_addr_reg;
      `OFF_INT_EN: rdata_next[6:0] = int_en_reg;
      `OFF_STATUS: rdata_next[14:0] = status_reg;
      `OFF_CLK_LOW: rdata_next[15:0] = clk_low_reg;
      `OFF_CLK_HIGH: rdata_next[15:0] = clk_high_reg;
      `OFF_COUNT: rdata_next[15:0] = count_reg;
      `OFF_RX_DATA: rdata_next[7:0] = rx_data_reg;
      `OFF_SLAVE_ADDR: rdata_next[9:0] = slave_addr_reg;
      `OFF_TX_DATA: rdata_next[7:0] = tx_byte;
      `OFF_MODE: rdata_next[15:0] = mode_reg;
      `OFF_VECTOR: rdata_next[2:0] = vec_code;
      `OFF_EXT_MODE: begin
        rdata_next[7:0] = ext_mode_reg;
        rdata_next[`EXT_RECOV_BUSY] = recov_busy;
        rdata_next[`EXT_RECOV_OK] = recov_ok;
      end
      `OFF_PRESCALE: rdata_next[7:0] = prescale_reg;
      `OFF_PERIPH_ID1: rdata_next = PERIPH_ID1;
      `OFF_PERIPH_ID2: rdata_next = PERIPH_ID2;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_addr_reg <= 10'h000;
      int_en_reg <= 7'h00;
      clk_low_reg <= 16'h0000;
      clk_high_reg <= 16'h0000;
      count_reg <= 16'h0000;
      slave_addr_reg <= 10'h3FF;
      tx_byte <= 8'h00;
      mode_reg <= 16'h0000;
      ext_mode_reg <= 8'h00;
      prescale_reg <= 8'h00;
    end else if (wr_acc) begin
      unique case (paddr)
        `OFF_OWN_ADDR: own_addr_reg <= pwdata[9:0];
        `OFF_INT_EN: int_en_reg <= pwdata[6:0];
        `OFF_CLK_LOW: clk_low_reg <= pwdata[15:0];
        `OFF_CLK_HIGH: clk_high_reg <= pwdata[15:0];
        `OFF_COUNT: count_reg <= pwdata[15:0];
        `OFF_SLAVE_ADDR: slave_addr_reg <= pwdata[9:0];
        `OFF_TX_DATA: tx_byte <= pwdata[7:0];
        `OFF_MODE: mode_reg <= pwdata[15:0];
        `OFF_EXT_MODE: ext_mode_reg <= {pwdata[7:4], 3'b000, pwdata[0]};
        `OFF_PRESCALE: prescale_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_reg <= 8'h00;
    end else if (core_evt.rx_copy) begin
      rx_data_reg <= rx_byte;
    end
  end

  // clear and set requests of the sticky status bits; set beats clear
  always_comb begin
    status_clr = 15'h0000;
    status_set = 15'h0000;
    if (wr_acc && paddr == `OFF_STATUS) begin
      status_clr = pwdata[14:0] & `ST_W1C_MASK;
    end
    if (rd_acc && paddr == `OFF_VECTOR && vec_code != 3'h0) begin
      status_clr[(vec_code == 3'h7) ? `ST_AAS : 32'(vec_code) - 1] = 1'b1;
    end
    if (rd_acc && paddr == `OFF_RX_DATA) begin
      status_clr[`ST_RRDY] = 1'b1;
    end
    if (core_evt.bus_free) begin
      status_clr[`ST_BB] = 1'b1;
      status_clr[`ST_SLAVE_TX_DIRECTION] = 1'b1;
    end
    status_set[`ST_AL] = core_evt.arb_lost;
    status_set[`ST_NO_ACK_EVENT] = core_evt.no_ack_event;
    status_set[`ST_REGS_READY] = core_evt.regs_ready;
    status_set[`ST_RRDY] = core_evt.rx_copy;
    status_set[`ST_XRDY] = core_evt.tx_load;
    status_set[`ST_SCD] = core_evt.stop_detected;
    status_set[`ST_BB] = core_evt.bus_busy_flag;
    status_set[`ST_NO_ACK_SENT] = core_evt.no_ack_sent;
    status_set[`ST_SLAVE_TX_DIRECTION] = core_evt.slave_tx_direction;
  end

  // status: soft reset forces defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= `ST_RESET;
    end else if (!module_run_enable) begin
      status_reg <= `ST_RESET;
    end else begin
      status_reg <= (status_reg & ~status_clr) | status_set;
      status_reg[`ST_AD0] <= core_evt.general_call_seen;
      status_reg[`ST_AAS] <= core_evt.addressed_as_slave;
      status_reg[`ST_TX_SHIFT_EMPTY_N] <= core_evt.tx_shift_empty_n;
      status_reg[`ST_RX_OVERRUN_FULL] <= core_evt.rx_overrun_full;
      status_reg[7:6] <= 2'b00;
    end
  end

  // events and interrupt outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      rx_dma_request <= 1'b0;
      tx_dma_request <= 1'b0;
      core_run <= 1'b0;
      addr_match <= 1'b0;
    end else begin
      irq <= |(sources & int_en_reg);
      rx_dma_request <= core_evt.rx_copy;
      tx_dma_request <= core_evt.tx_load;
      core_run <= module_run_enable && (mode_reg[`MODE_FREE] || !sync2_reg[2]);
      addr_match <= match_raw;
    end
  end

  own_addr_match u_match (
    .own_addr_field(own_addr_reg),
    .ten_bit_addr_select(mode_reg[`MODE_XA]),
    .rx_addr(rx_slave_addr),
    .match(match_raw)
  );

  bus_recovery #(
    .HALF_CYC(RECOV_HALF),
    .MAX_PULSES(`RECOV_MAX_PULSES)
  ) u_recov (
    .pclk(pclk),
    .presetn(presetn),
    .start(recov_start),
    .sda_sync(sync2_reg[1]),
    .scl_sync(sync2_reg[0]),
    .scl_oe(scl_oe),
    .busy(recov_busy),
    .released(recov_ok)
  );

  property p_rx_event;
    @(posedge pclk) disable iff (!presetn)
    core_evt.rx_copy |=> rx_dma_request;
  endproperty
  a_rx_event: assert property (p_rx_event) else $error("rx dma event missing");

  property p_tx_event;
    @(posedge pclk) disable iff (!presetn)
    core_evt.tx_load |=> tx_dma_request ##0 status_reg[`ST_XRDY];
  endproperty
  a_tx_event: assert property (p_tx_event) else $error("tx dma event missing");

  property p_single_pulse;
    @(posedge pclk) disable iff (!presetn)
    rx_dma_request |-> $past(core_evt.rx_copy);
  endproperty
  a_single_pulse: assert property (p_single_pulse) else $error("stray rx dma event");

  property p_irq_gate;
    @(posedge pclk) disable iff (!presetn)
    ##1 irq == $past(|(sources & int_en_reg));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated by enables");

  property p_reset_status;
    @(posedge pclk) $rose(presetn) |-> status_reg == `ST_RESET;
  endproperty
  a_reset_status: assert property (p_reset_status) else $error("status reset value wrong");

  property p_w1c;
    @(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == `OFF_STATUS && pwdata[`ST_NO_ACK_EVENT] && !core_evt.no_ack_event
      |=> !status_reg[`ST_NO_ACK_EVENT];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
    pready && !pwrite && paddr == `OFF_STATUS |-> prdata[31:15] == 17'h00000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  sequence s_halt_held;
    !mode_reg[`MODE_FREE] && debug_suspend [*4];
  endsequence
  property p_suspend;
    @(posedge pclk) disable iff (!presetn)
    s_halt_held |-> !core_run;
  endproperty
  a_suspend: assert property (p_suspend) else $error("core ran during suspend");

  property p_vector_clear;
    @(posedge pclk) disable iff (!presetn)
    rd_acc && paddr == `OFF_VECTOR && vec_code == 3'h1 && module_run_enable && !core_evt.arb_lost
      |=> !status_reg[`ST_AL];
  endproperty
  a_vector_clear: assert property (p_vector_clear) else $error("vector read kept flag");

  property p_read_only;
    @(posedge pclk) disable iff (!presetn)
    module_run_enable && wr_acc && paddr == `OFF_STATUS && core_evt.addressed_as_slave
      |=> status_reg[`ST_AAS];
  endproperty
  a_read_only: assert property (p_read_only) else $error("read-only status bit cleared");

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
    module_run_enable && core_evt.arb_lost |=> status_reg[`ST_AL];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event flag not set");

endmodule : i2c_event_register_front
`default_nettype wire

// File: hw/i2c_front_params.svh
/*
  constants of the two-wire controller front end: offsets, fields, resets, timing.
  assumes inclusion by bare name from the design files.
*/
`ifndef I2C_FRONT_PARAMS_SVH
`define I2C_FRONT_PARAMS_SVH

`define OFF_OWN_ADDR 8'h00
`define OFF_INT_EN 8'h04
`define OFF_STATUS 8'h08
`define OFF_CLK_LOW 8'h0C
`define OFF_CLK_HIGH 8'h10
`define OFF_COUNT 8'h14
`define OFF_RX_DATA 8'h18
`define OFF_SLAVE_ADDR 8'h1C
`define OFF_TX_DATA 8'h20
`define OFF_MODE 8'h24
`define OFF_VECTOR 8'h28
`define OFF_EXT_MODE 8'h2C
`define OFF_PRESCALE 8'h30
`define OFF_PERIPH_ID1 8'h34
`define OFF_PERIPH_ID2 8'h38

`define ST_AL 0
`define ST_NO_ACK_EVENT 1
`define ST_REGS_READY 2
`define ST_RRDY 3
`define ST_XRDY 4
`define ST_SCD 5
`define ST_AD0 8
`define ST_AAS 9
`define ST_TX_SHIFT_EMPTY_N 10
`define ST_RX_OVERRUN_FULL 11
`define ST_BB 12
`define ST_NO_ACK_SENT 13
`define ST_SLAVE_TX_DIRECTION 14
`define ST_W1C_MASK 15'h703F
`define ST_RESET 15'h0410

`define MODE_XA 8
`define MODE_IRS 5
`define MODE_FREE 14
`define EXT_RECOV_START 1
`define EXT_RECOV_BUSY 2
`define EXT_RECOV_OK 3

`define PCLK_NS 8
`define RECOV_HALF_NS 5000
`define RECOV_HALF_CYC ((`RECOV_HALF_NS + `PCLK_NS - 1) / `PCLK_NS)
`define RECOV_MAX_PULSES 9
`define SYNC_LAT 3

`endif

// File: hw/i2c_front_pkg.sv
/*
  types of the two-wire controller front end.
  assumes nothing; constants live in i2c_front_params.svh.
*/
package i2c_front_pkg;

  typedef struct packed {
    logic arb_lost;
    logic no_ack_event;
    logic regs_ready;
    logic stop_detected;
    logic rx_copy;
    logic tx_load;
    logic addressed_as_slave;
    logic general_call_seen;
    logic rx_overrun_full;
    logic tx_shift_empty_n;
    logic slave_tx_direction;
    logic no_ack_sent;
    logic bus_busy_flag;
    logic bus_free;
  } core_evt_t;

  typedef enum logic [2:0] {
    REC_IDLE = 3'b001,
    REC_LOW = 3'b010,
    REC_HIGH = 3'b100
  } recov_state_t;

endpackage : i2c_front_pkg

// File: hw/own_addr_match.sv
/*
  own slave address comparison for 7-bit and 10-bit addressing.
  assumes the received address is stable while it is compared.
*/
`timescale 1ns/10ps
`default_nettype none

module own_addr_match (
  input wire logic [9:0] own_addr_field,
  input wire logic ten_bit_addr_select,
  input wire logic [9:0] rx_addr,
  output logic match
);

  always_comb begin
    if (ten_bit_addr_select) begin
      match = (own_addr_field == rx_addr);
    end else begin
      match = (own_addr_field[6:0] == rx_addr[6:0]);
    end
  end

endmodule : own_addr_match
`default_nettype wire

// File: verification/i2c_bus_model.sv
/*
  two-wire bus seen from the controller: pull-ups on both lines and one slave
  that holds the data line low for a set number of clock pulses.
  assumes scl_oe high means the controller pulls the clock line low.
*/
`timescale 1ns/10ps
`default_nettype none

module i2c_bus_model (
  input wire logic scl_oe,
  input wire logic clr,
  input var int hold,
  output logic scl,
  output logic sda,
  output var int pulses
);
  // only the controller pulls the clock line low, the pull-up does the rest
  assign scl = scl_oe ? 1'b0 : 1'b1;
  // the slave moves the data line only while the clock is low
  always @(posedge scl_oe or posedge clr) begin
    if (clr) begin
      pulses <= 0;
    end else begin
      pulses <= pulses + 1;
    end
  end
  assign sda = (pulses >= hold);
endmodule : i2c_bus_model

`default_nettype wire

// File: verification/i2c_event_register_front_tb.sv
/*
  self-checking bench of the controller front end, driven over apb.
  assumes the design files and i2c_bus_model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "i2c_front_params.svh"

module i2c_event_register_front_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, irq, rx_req, tx_req, core_run, addr_match, scl_oe, sda, scl;
  i2c_front_pkg::core_evt_t ce;
  logic [7:0] rx_byte = 8'h00;
  logic [9:0] rx_addr = 10'h000;
  logic [7:0] tx_byte;
  logic dbg = 1'b0;
  logic clr = 1'b0;
  int hold = 3;
  int pulses;
  int n_errors = 0;
  int n_compared = 0;

  always #4 pclk = ~pclk;

  i2c_event_register_front #(.RECOV_HALF(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_evt(ce), .rx_byte(rx_byte), .rx_slave_addr(rx_addr), .debug_suspend(dbg),
    .sda_in(sda), .scl_in(scl), .irq(irq), .rx_dma_request(rx_req),
    .tx_dma_request(tx_req), .core_run(core_run), .addr_match(addr_match),
    .tx_byte(tx_byte), .scl_oe(scl_oe)
  );

  i2c_bus_model u_bus (
    .scl_oe(scl_oe), .clr(clr), .hold(hold), .scl(scl), .sda(sda), .pulses(pulses)
  );

  task automatic end_of_test;
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] d, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, wd, d, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0000_0000, d, e);
  endtask : rd

  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      $display("MISMATCH %s expected %h seen %h", s, x, g);
      n_errors++;
    end
  endtask : chk

  task automatic chr(input string s, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] d;
    rd(a, d);
    chk(s, x, d);
  endtask : chr

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : wt

  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    end_of_test();
  end

  initial begin
    logic [31:0] d;
    logic e;
    ce = '0;
    ce.tx_shift_empty_n = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chr("status_reset", `OFF_STATUS, 32'h0000_0410);
    chr("slave_addr_reset", `OFF_SLAVE_ADDR, 32'h0000_03FF);
    wr(`OFF_MODE, 32'h0000_0020);
    wr(`OFF_INT_EN, 32'hFFFF_FFFF);
    chr("int_en", `OFF_INT_EN, 32'h0000_007F);
    wr(`OFF_INT_EN, 32'h0000_0000);
    wr(`OFF_OWN_ADDR, 32'hFFFF_FFFF);
    chr("own_addr", `OFF_OWN_ADDR, 32'h0000_03FF);
    // each register keeps its own value at its own offset
    wr(`OFF_CLK_LOW, 32'hFFFF_FFFF);
    wr(`OFF_CLK_HIGH, 32'h0000_1234);
    wr(`OFF_COUNT, 32'hFFFF_5678);
    wr(`OFF_SLAVE_ADDR, 32'h0000_0155);
    wr(`OFF_PRESCALE, 32'h0000_01C3);
    chr("clk_low", `OFF_CLK_LOW, 32'h0000_FFFF);
    chr("clk_high", `OFF_CLK_HIGH, 32'h0000_1234);
    chr("count", `OFF_COUNT, 32'h0000_5678);
    chr("slave_addr", `OFF_SLAVE_ADDR, 32'h0000_0155);
    chr("prescale", `OFF_PRESCALE, 32'h0000_00C3);
    chr("mode", `OFF_MODE, 32'h0000_0020);
    apb(1'b0, 8'h3C, 32'h0000_0000, d, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, d);
    apb(1'b1, 8'h02, 32'h0000_0001, d, e);
    chk("misaligned_err", 32'h1, {31'h0, e});
    // two events land while masked
    @(posedge pclk);
    ce.arb_lost <= 1'b1;
    ce.no_ack_event <= 1'b1;
    @(posedge pclk);
    ce.arb_lost <= 1'b0;
    ce.no_ack_event <= 1'b0;
    wt(3);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(`OFF_STATUS, 32'h0000_0000);
    chr("status_w0", `OFF_STATUS, 32'h0000_0413);
    wr(`OFF_INT_EN, 32'h0000_0003);
    wt(3);
    chk("irq_on", 32'h1, {31'h0, irq});
    chr("vector_first", `OFF_VECTOR, 32'h0000_0001);
    wt(3);
    chk("irq_again", 32'h1, {31'h0, irq});
    chr("vector_second", `OFF_VECTOR, 32'h0000_0002);
    wt(3);
    chk("irq_off", 32'h0, {31'h0, irq});
    wr(`OFF_STATUS, 32'hFFFF_FFFF);
    chr("status_w1c", `OFF_STATUS, 32'h0000_0400);
    // receive byte reaches the data register and pulses the rx dma request, an apb read takes it
    wr(`OFF_INT_EN, 32'h0000_0008);
    @(posedge pclk);
    ce.rx_copy <= 1'b1;
    rx_byte <= 8'hA5;
    @(posedge pclk);
    ce.rx_copy <= 1'b0;
    #1;
    chk("rx_req", 32'h1, {31'h0, rx_req});
    wt(1);
    chk("rx_req_end", 32'h0, {31'h0, rx_req});
    chk("irq_rx", 32'h1, {31'h0, irq});
    chr("rx_data", `OFF_RX_DATA, 32'h0000_00A5);
    wt(3);
    chk("irq_rx_read", 32'h0, {31'h0, irq});
    @(posedge pclk);
    ce.tx_load <= 1'b1;
    @(posedge pclk);
    ce.tx_load <= 1'b0;
    #1;
    chk("tx_req", 32'h1, {31'h0, tx_req});
    wt(1);
    chk("tx_req_end", 32'h0, {31'h0, tx_req});
    wr(`OFF_TX_DATA, 32'h0000_015A);
    wt(1);
    chk("tx_byte", 32'h0000_005A, {24'h0, tx_byte});
    // core flags and levels; writing ones leaves the read-only bits alone
    @(posedge pclk);
    ce.regs_ready <= 1'b1;
    ce.stop_detected <= 1'b1;
    ce.bus_busy_flag <= 1'b1;
    ce.no_ack_sent <= 1'b1;
    ce.slave_tx_direction <= 1'b1;
    ce.addressed_as_slave <= 1'b1;
    ce.general_call_seen <= 1'b1;
    ce.rx_overrun_full <= 1'b1;
    @(posedge pclk);
    ce.regs_ready <= 1'b0;
    ce.stop_detected <= 1'b0;
    ce.bus_busy_flag <= 1'b0;
    ce.no_ack_sent <= 1'b0;
    ce.slave_tx_direction <= 1'b0;
    chr("status_flags", `OFF_STATUS, 32'h0000_7F34);
    @(posedge pclk);
    ce.bus_free <= 1'b1;
    @(posedge pclk);
    ce.bus_free <= 1'b0;
    chr("status_bus_free", `OFF_STATUS, 32'h0000_2F34);
    wr(`OFF_STATUS, 32'hFFFF_FFFF);
    chr("status_ro", `OFF_STATUS, 32'h0000_0F00);
    wr(`OFF_INT_EN, 32'h0000_0040);
    wt(3);
    chk("irq_aas", 32'h1, {31'h0, irq});
    chr("vector_aas", `OFF_VECTOR, 32'h0000_0007);
    ce.addressed_as_slave <= 1'b0;
    ce.general_call_seen <= 1'b0;
    ce.rx_overrun_full <= 1'b0;
    wt(3);
    chk("irq_aas_off", 32'h0, {31'h0, irq});
    // upper own address bits only count in ten-bit mode
    wr(`OFF_OWN_ADDR, 32'h0000_03AB);
    rx_addr <= 10'h1AB;
    wt(2);
    chk("match_seven", 32'h1, {31'h0, addr_match});
    wr(`OFF_MODE, 32'h0000_0120);
    wt(2);
    chk("nomatch_ten", 32'h0, {31'h0, addr_match});
    @(posedge pclk);
    rx_addr <= 10'h3AB;
    wt(2);
    chk("match_ten", 32'h1, {31'h0, addr_match});
    @(posedge pclk);
    dbg <= 1'b1;
    wt(5);
    chk("run_halted", 32'h0, {31'h0, core_run});
    wr(`OFF_MODE, 32'h0000_4020);
    wt(2);
    chk("run_free", 32'h1, {31'h0, core_run});
    // slave lets go after three pulses, then never
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      hold <= (i == 0) ? 3 : 20;
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      wr(`OFF_EXT_MODE, 32'h0000_0002);
      d = 32'h0000_0004;
      for (int n = 0; n < 100 && d[2]; n++) begin
        rd(`OFF_EXT_MODE, d);
      end
      chk("recov_flags", (i == 0) ? 32'h8 : 32'h0, d & 32'h0000_000E);
      chk("recov_pulses", (i == 0) ? 32'd3 : 32'd9, pulses);
    end
    end_of_test();
  end
endmodule : i2c_event_register_front_tb

`default_nettype wire
